/* rtl/wdcw_pkg.sv */
// Constants shared by the watchdog control word logic.
package wdcw_pkg;

  // ===========================================================
  // Register map (byte addresses on the APB bus).
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_MASK = 12'h008;

  // ===========================================================
  // Control word fields.
  localparam logic [7:0] KEY_READ = 8'h69;
  localparam logic [7:0] KEY_WRITE = 8'h5A;
  localparam int KEY_LSB = 8;
  localparam int FREEZE_POS = 7;
  localparam int CLK_PICK_LSB = 5;
  localparam int KIND_POS = 4;
  localparam int WIPE_POS = 3;
  localparam int PERIOD_LSB = 0;

  // ===========================================================
  // Values after reset; the control word fields also after a power-up-clear.
  localparam logic FREEZE_RST = 1'h0;
  localparam logic [1:0] CLK_PICK_RST = 2'h0;
  localparam logic KIND_RST = 1'h0;
  localparam logic [2:0] PERIOD_RST = 3'h4;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;

  // ===========================================================
  // Clock pick encodings.
  localparam logic [1:0] CLK_SUBSYS = 2'h0;
  localparam logic [1:0] CLK_AUX = 2'h1;
  localparam logic [1:0] CLK_VLO = 2'h2;
  localparam logic [1:0] CLK_EXTRA = 2'h3;

  // ===========================================================
  // Counter bit watched for each period pick code; dividing by 2^n
  // watches bit n-1.  Entry k belongs to code k.
  localparam logic [7:0][4:0] TAP_BIT = {
    5'h05, 5'h08, 5'h0C, 5'h0E, 5'h12, 5'h16, 5'h1A, 5'h1E
  };

  // Mode kinds.
  localparam logic KIND_WATCHDOG = 1'h0;
  localparam logic KIND_INTERVAL = 1'h1;

endpackage

/* rtl/wdcw_edge.sv */
// Rising edge detector for a selected count clock level.
`timescale 1ns/1ps
module wdcw_edge
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Level in, pulse out
  input wire logic level_i,
  output logic rise_o
);

  typedef struct packed {
    logic prev;
    logic rise;
  } wdcw_edge_s;

  wdcw_edge_s st_r;
  wdcw_edge_s st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.prev = level_i;
    st_nxt.rise = level_i & ~st_r.prev;
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign rise_o = st_r.rise;

endmodule

/* rtl/wdcw_counter.sv */
// Internal up-counter with period tap and expiry pulse.
`timescale 1ns/1ps
module wdcw_counter
#(
  parameter int WIDTH = 32
)
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Control
  input wire logic tick_i,
  input wire logic freeze_i,
  input wire logic clear_i,
  input wire logic [2:0] period_i,
  // Result
  output logic expire_o
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic tap;
    logic expire;
  } wdcw_counter_s;

  wdcw_counter_s st_r;
  wdcw_counter_s st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.expire = 1'h0;
    if (clear_i)
    begin
      st_nxt.cnt = '0;
      st_nxt.tap = 1'h0;
    end
    else
    begin
      if (tick_i && !freeze_i)
      begin
        st_nxt.cnt = st_r.cnt + {{(WIDTH-1){1'h0}}, 1'h1};
      end
      // A new tap pick may itself look like an edge; software is
      // expected to wipe the count when changing the period.
      st_nxt.tap = st_nxt.cnt[wdcw_pkg::TAP_BIT[period_i]];
      st_nxt.expire = st_nxt.tap & ~st_r.tap;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign expire_o = st_r.expire;

endmodule

/* rtl/wdcw_top.sv */
// Watchdog control word logic with APB register access.
// Operation
// - Reads of the control word return 69h in bits 15-8.
// - A control word write whose key is not 5Ah raises a power-up-clear.
// - The freeze bit at 7 stops the counter while set.
// - Bits 6-5 pick subsystem, auxiliary, low-power or extra clock.
// - Bit 4 picks watchdog (0) or interval (1) behaviour on expiry.
// - Writing 1 to bit 3 zeroes the counter, writing 0 does nothing.
// - Bit 3 clears itself and always reads back as zero.
// - Bits 2-0 pick the expiry period and come up as 4h.
// - Period codes 0 to 7 divide by 2^31,27,23,19,15,13,9,6.
// - After a power-up-clear it is a watchdog on the subsystem clock.
// - Watchdog-mode expiry raises a power-up-clear and sets the flag.
// - Interval-mode expiry sets the flag only; software clears it.
// - A write to the control word that is not a full 16-bit word resets.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module wdcw_top
#(
  parameter int CNT_WIDTH = 32
)
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Count clock sources, sampled as levels
  input wire logic subsystem_master_clock_i,
  input wire logic aux_clock_i,
  input wire logic very_low_power_osc_clock_i,
  input wire logic extra_clock_i,
  // System outputs
  output logic power_up_clear_reset_o,
  output logic irq_o
);

  // ===========================================================
  // State.
  typedef enum logic [2:0]
  {
    BUS_IDLE = 3'h1,
    BUS_OKAY = 3'h2,
    BUS_FAULT = 3'h4
  } wdcw_bus_e;

  typedef struct packed {
    logic freeze;
    logic [1:0] clk_pick;
    logic kind;
    logic [2:0] period;
    logic wipe;
    logic power_up_clear_reset;
    logic [7:0] status;
    logic [7:0] mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    wdcw_bus_e phase;
  } wdcw_top_s;

  wdcw_top_s st_r;
  wdcw_top_s st_nxt;

  logic sel_level;
  logic tick;
  logic expire;
  logic acc_go;
  logic acc_done;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_mask;
  logic bad_key;
  logic part_wr;
  logic puc_evt;
  logic [15:0] ctrl_view;
  logic [31:0] rd_word;
  logic hit_any;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_stat;

  // ===========================================================
  // Count clock selection.
  always_comb
  begin
    case (st_r.clk_pick)
      wdcw_pkg::CLK_SUBSYS: sel_level = subsystem_master_clock_i;
      wdcw_pkg::CLK_AUX: sel_level = aux_clock_i;
      wdcw_pkg::CLK_VLO: sel_level = very_low_power_osc_clock_i;
      wdcw_pkg::CLK_EXTRA: sel_level = extra_clock_i;
      default: sel_level = subsystem_master_clock_i;
    endcase
  end

  // Source changes while running may give one stray edge; halting
  // first avoids a short interval.
  wdcw_edge u_edge
  (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .level_i(sel_level),
    .rise_o(tick)
  );

  wdcw_counter #(.WIDTH(CNT_WIDTH)) u_counter
  (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .tick_i(tick),
    .freeze_i(st_r.freeze),
    .clear_i(st_r.wipe),
    .period_i(st_r.period),
    .expire_o(expire)
  );

  // ===========================================================
  // Bus decode.
  assign acc_go = psel_i & penable_i & ~st_r.pready;
  assign acc_done = psel_i & penable_i & st_r.pready;
  assign hit_ctrl = (paddr_i == wdcw_pkg::ADDR_CTRL);
  assign hit_stat = (paddr_i == wdcw_pkg::ADDR_STAT);
  assign hit_mask = (paddr_i == wdcw_pkg::ADDR_MASK);
  assign bad_key = (pwdata_i[wdcw_pkg::KEY_LSB +: 8]
                    != wdcw_pkg::KEY_WRITE);
  assign part_wr = (pstrb_i[1:0] != 2'h3);
  // Register side effects happen only at the edge that completes a transfer.
  assign hit_any = hit_ctrl | hit_stat | hit_mask;
  assign wr_ctrl = acc_done & pwrite_i & hit_ctrl;
  assign wr_mask = acc_done & pwrite_i & hit_mask;
  assign rd_stat = acc_done & ~pwrite_i & hit_stat;

  assign ctrl_view = {wdcw_pkg::KEY_READ,
                      st_r.freeze,
                      st_r.clk_pick,
                      st_r.kind,
                      1'b0,
                      st_r.period};

  // ===========================================================
  // Read data.
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (!pwrite_i)
    begin
      case (paddr_i)
        wdcw_pkg::ADDR_CTRL:
        begin
          rd_word = {16'h0000, ctrl_view};
        end
        wdcw_pkg::ADDR_STAT:
        begin
          rd_word = {24'h00_0000, st_r.status};
        end
        wdcw_pkg::ADDR_MASK:
        begin
          rd_word = {24'h00_0000, st_r.mask};
        end
        default:
        begin
          rd_word = 32'h0000_0000;
        end
      endcase
    end
  end

  // ===========================================================
  // Next state.
  always_comb
  begin
    st_nxt = st_r;
    puc_evt = 1'b0;
    st_nxt.wipe = 1'b0;
    st_nxt.power_up_clear_reset = 1'b0;

    // One wait state: the answer is prepared at the first access edge
    // and shown for exactly one cycle, so pready never lingers high.
    case (st_r.phase)
      BUS_IDLE:
      begin
        if (acc_go)
        begin
          if (hit_any)
          begin
            st_nxt.phase = BUS_OKAY;
          end
          else
          begin
            st_nxt.phase = BUS_FAULT;
          end
        end
      end
      BUS_OKAY:
      begin
        st_nxt.phase = BUS_IDLE;
      end
      BUS_FAULT:
      begin
        st_nxt.phase = BUS_IDLE;
      end
      default:
      begin
        st_nxt.phase = BUS_IDLE;
      end
    endcase
    st_nxt.pready = (st_nxt.phase != BUS_IDLE);
    st_nxt.pslverr = (st_nxt.phase == BUS_FAULT);
    if (acc_go)
    begin
      st_nxt.prdata = rd_word;
    end

    // Read-clear drops only the bits that were returned, so an event
    // landing in the same cycle survives.
    if (rd_stat)
    begin
      st_nxt.status = st_r.status & ~st_r.prdata[7:0];
    end

    if (wr_mask)
    begin
      st_nxt.mask = pwdata_i[7:0];
    end

    if (wr_ctrl)
    begin
      if (part_wr)
      begin
        puc_evt = 1'b1;
      end
      else if (bad_key)
      begin
        puc_evt = 1'b1;
      end
      else
      begin
        st_nxt.freeze = pwdata_i[wdcw_pkg::FREEZE_POS];
        st_nxt.clk_pick = pwdata_i[wdcw_pkg::CLK_PICK_LSB +: 2];
        st_nxt.kind = pwdata_i[wdcw_pkg::KIND_POS];
        st_nxt.period = pwdata_i[wdcw_pkg::PERIOD_LSB +: 3];
        st_nxt.wipe = pwdata_i[wdcw_pkg::WIPE_POS];
      end
    end

    if (expire)
    begin
      st_nxt.status[0] = 1'b1;
      if (st_r.kind == wdcw_pkg::KIND_WATCHDOG)
      begin
        puc_evt = 1'b1;
      end
    end

    // A power-up-clear puts the control word back to its defaults and
    // wipes the count; the flag is set so the cause can be read.
    if (puc_evt)
    begin
      st_nxt.status[0] = 1'b1;
      st_nxt.power_up_clear_reset = 1'b1;
      st_nxt.wipe = 1'b1;
      st_nxt.freeze = wdcw_pkg::FREEZE_RST;
      st_nxt.clk_pick = wdcw_pkg::CLK_PICK_RST;
      st_nxt.kind = wdcw_pkg::KIND_RST;
      st_nxt.period = wdcw_pkg::PERIOD_RST;
    end

    st_nxt.irq = |(st_nxt.status & st_nxt.mask);
  end

  // ===========================================================
  // Registers.
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= '0;
      st_r.freeze <= wdcw_pkg::FREEZE_RST;
      st_r.clk_pick <= wdcw_pkg::CLK_PICK_RST;
      st_r.kind <= wdcw_pkg::KIND_RST;
      st_r.period <= wdcw_pkg::PERIOD_RST;
      st_r.status <= wdcw_pkg::STAT_RST;
      st_r.mask <= wdcw_pkg::MASK_RST;
      st_r.phase <= BUS_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign prdata_o = st_r.prdata;
  assign pready_o = st_r.pready;
  assign pslverr_o = st_r.pslverr;
  assign power_up_clear_reset_o = st_r.power_up_clear_reset;
  assign irq_o = st_r.irq;

endmodule

/* tb/wdcw_sva.sv */
// Concurrent checks on the watchdog control word block ports.
`timescale 1ns/1ps
module wdcw_sva
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  // System
  input wire logic power_up_clear_reset_o,
  input wire logic irq_o
);
  // ==========================================================
  // Shadow state
  logic done, wr, rd, bad, msk_r;
  logic [7:0] sh_r;
  logic [2:0] qt_r;
  assign done = psel_i && penable_i && pready_o;
  assign wr = done && pwrite_i && paddr_i == wdcw_pkg::ADDR_CTRL;
  assign rd = done && !pwrite_i && paddr_i == wdcw_pkg::ADDR_CTRL;
  assign bad = wr && (pwdata_i[15:8] != wdcw_pkg::KEY_WRITE
    || pstrb_i[1:0] != 2'h3);
  // The quiet count lets pulses already in the pipeline drain first.
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i || power_up_clear_reset_o)
    begin
      sh_r <= 8'h04;
      qt_r <= 3'h0;
    end
    else if (wr && !bad)
    begin
      sh_r <= pwdata_i[7:0] & 8'hF7;
      qt_r <= 3'h0;
    end
    else if (qt_r != 3'h7)
      qt_r <= qt_r + 3'h1;
  end
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      msk_r <= 1'h0;
    else if (done && pwrite_i && paddr_i == wdcw_pkg::ADDR_MASK)
      msk_r <= pwdata_i[0];
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_bad_key;
    wr && pwdata_i[15:8] != wdcw_pkg::KEY_WRITE;
  endsequence
  property p_key_read;
    rd |-> prdata_o[15:8] == wdcw_pkg::KEY_READ;
  endproperty
  a_key_read: assert property (p_key_read) else $error("key field");
  property p_bad_key;
    s_bad_key |=> power_up_clear_reset_o;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("no reset");
  property p_freeze;
    sh_r[7] && qt_r >= 3'h5 && !$past(bad) |-> !power_up_clear_reset_o;
  endproperty
  a_freeze: assert property (p_freeze) else $error("frozen");
  property p_ctrl_read;
    rd |-> prdata_o[7:0] == sh_r;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("fields");
  property p_wipe_zero;
    rd |-> !prdata_o[3];
  endproperty
  a_wipe_zero: assert property (p_wipe_zero) else $error("wipe");
  property p_interval;
    sh_r[4] && qt_r >= 3'h5 && !$past(bad) |-> !power_up_clear_reset_o;
  endproperty
  a_interval: assert property (p_interval) else $error("reset");
  property p_byte;
    wr && pstrb_i[1:0] != 2'h3 |=> power_up_clear_reset_o;
  endproperty
  a_byte: assert property (p_byte) else $error("byte write");
  property p_flag;
    power_up_clear_reset_o && msk_r |-> ##[0:1] irq_o;
  endproperty
  a_flag: assert property (p_flag) else $error("flag");
endmodule
bind wdcw_top wdcw_sva u_wdcw_sva
(
  .clock_i,
  .sys_rst_i,
  .psel_i,
  .penable_i,
  .pwrite_i,
  .paddr_i,
  .pwdata_i,
  .pstrb_i,
  .prdata_o,
  .pready_o,
  .power_up_clear_reset_o,
  .irq_o
);

/* tb/wdcw_test.sv */
// Self-checking bench for the watchdog control word block.
`timescale 1ns/1ps
module wdcw_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [3:0] pstb = 4'h0;
  logic [3:0] src = 4'h0;
  logic [31:0] prd, q;
  logic rdy, err, e, power_up_clear_reset, irq;
  int err_count = 0;
  int check_count = 0;
  int pucs = 0;
  int cyc = 0;
  wdcw_top u_wdcw_top
  (
    .clock_i(clk),
    .sys_rst_i(rst),
    .psel_i(psel),
    .penable_i(pen),
    .pwrite_i(pwr),
    .paddr_i(padr),
    .pwdata_i(pwd),
    .pstrb_i(pstb),
    .prdata_o(prd),
    .pready_o(rdy),
    .pslverr_o(err),
    .subsystem_master_clock_i(src[0]),
    .aux_clock_i(src[1]),
    .very_low_power_osc_clock_i(src[2]),
    .extra_clock_i(src[3]),
    .power_up_clear_reset_o(power_up_clear_reset),
    .irq_o(irq)
  );
  initial
  begin
    forever #20 clk = ~clk;
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // The longest period run takes about 33000 cycles.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (power_up_clear_reset === 1'b1)
      pucs <= pucs + 1;
    if (cyc == 60000)
    begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input string n, input logic [31:0] s,
    input logic [31:0] x);
    check_count++;
    if (s !== x)
    begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, x, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    pstb <= s;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (rdy !== 1'b1);
    q = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [11:0] a,
    input logic [31:0] x);
    xfer(1'b0, a, 32'h0, 4'h0);
    chk(n, q, x);
  endtask
  // Each count clock rise is held one cycle, then low one cycle, so the sampler sees it.
  task automatic tick(input int k, input int n);
    repeat (n)
    begin
      @(posedge clk);
      src[k] <= 1'b1;
      @(posedge clk);
      src[k] <= 1'b0;
    end
    repeat (6) @(posedge clk);
  endtask
  task automatic run(input logic [1:0] k, input logic [2:0] c,
    input int n);
    xfer(1'b1, 12'h000, {16'h0, 8'h5A, 1'b0, k, 2'h3, c}, 4'h3);
    xfer(1'b0, 12'h004, 32'h0, 4'h0);
    tick(k, n - 1);
    chk("early", irq, 32'h0);
    tick(k, 1);
    chk("irq", irq, 32'h1);
    rd("ctrl", 12'h000, {16'h0, 8'h69, 1'b0, k, 2'h2, c});
    rd("stat", 12'h004, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq clr", irq, 32'h0);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd("reset", 12'h000, 32'h6904);
    xfer(1'b1, 12'h008, 32'h1, 4'hF);
    rd("mask", 12'h008, 32'h1);
    xfer(1'b0, 12'h00C, 32'h0, 4'h0);
    chk("slverr", e, 32'h1);
    xfer(1'b1, 12'h000, 32'h1280, 4'h3);
    repeat (3) @(posedge clk);
    chk("puc key", pucs, 32'h1);
    chk("irq puc", irq, 32'h1);
    xfer(1'b1, 12'h000, 32'h5A80, 4'h1);
    repeat (3) @(posedge clk);
    chk("puc byte", pucs, 32'h2);
    rd("no update", 12'h000, 32'h6904);
    xfer(1'b1, 12'h000, 32'h5A8F, 4'h3);
    tick(0, 40);
    chk("frozen", pucs, 32'h2);
    rd("freeze", 12'h000, 32'h6987);
    xfer(1'b1, 12'h000, 32'h5A0F, 4'h3);
    tick(0, 31);
    chk("no timeout", pucs, 32'h2);
    tick(0, 1);
    chk("timeout", pucs, 32'h3);
    rd("defaults", 12'h000, 32'h6904);
    xfer(1'b1, 12'h000, 32'h5A1F, 4'h3);
    rd("cause", 12'h004, 32'h1);
    tick(0, 20);
    xfer(1'b1, 12'h000, 32'h5A1F, 4'h3);
    tick(0, 20);
    chk("wiped", irq, 32'h0);
    xfer(1'b1, 12'h000, 32'h5A17, 4'h3);
    tick(0, 12);
    chk("not wiped", irq, 32'h1);
    for (int k = 0; k < 4; k++)
      run(2'(k), 3'h7, 32);
    run(2'h0, 3'h6, 256);
    run(2'h0, 3'h5, 4096);
    run(2'h0, 3'h4, 16384);
    chk("no puc", pucs, 32'h3);
    wrap_up();
  end
endmodule
